//--- rtl/ppm_port_mux.sv
// port b pin override multiplexer with its direction, latch and control registers
`timescale 1ns/1ns
module ppm_port_mux (
    input wire logic clk,
    input wire logic reset_n,
    input wire ppm_pkg::ppm_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    input wire ppm_pkg::ppm_override_t ovr_in,
    input wire ppm_pkg::ppm_alt_t alt_in,
    input wire logic sleep_clamp_mode,
    input wire logic [7:0] ext_irq_enable,
    input wire logic [7:0] schmitt_in,
    output ppm_pkg::ppm_pad_t pad_out,
    output logic [7:0] raw_pad_input,
    output logic [7:0] pin_input_sample,
    output logic timer16_ext_clock_in,
    output logic [4:0] pin_change_src,
    output logic global_pullup_disable
);
    import ppm_pkg::*;

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    logic [7:0] pin_direction_reg;
    logic [7:0] pin_output_latch_reg;
    logic [7:0] mcu_control_reg;
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] clamp_in;
    logic [7:0] in_en;
    ppm_override_t ovr;
    logic wr_dir;
    logic wr_latch;
    logic wr_input;
    logic wr_ctrl;

    // one write decode shared by every register
    function automatic logic wr_hit(input ppm_bus_req_t req, input logic [3:0] addr);
        return req.wr && req.addr == addr;
    endfunction : wr_hit

    assign wr_dir = wr_hit(bus_req, PPM_ADDR_DIR);
    assign wr_latch = wr_hit(bus_req, PPM_ADDR_LATCH);
    assign wr_input = wr_hit(bus_req, PPM_ADDR_INPUT);
    assign wr_ctrl = wr_hit(bus_req, PPM_ADDR_MCU_CONTROL);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_direction_reg <= PPM_PORT_RESET;
        end else if (wr_dir) begin
            pin_direction_reg <= bus_req.wdata; // RULE23
        end
    end

    // a write to the latch address and a toggle in one cycle: toggle acts on the new value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_output_latch_reg <= PPM_PORT_RESET;
        end else begin
            pin_output_latch_reg <= (wr_latch ? bus_req.wdata : pin_output_latch_reg)
                ^ (wr_input ? bus_req.wdata : 8'h00) // RULE22
                ^ ovr.latch_toggle_override_en; // RULE9
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mcu_control_reg <= PPM_MCU_CONTROL_RESET;
        end else if (wr_ctrl) begin
            mcu_control_reg <= bus_req.wdata & PPM_MCU_CONTROL_WMASK; // RULE13
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_rdata <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                PPM_ADDR_INPUT: bus_rdata <= sync2_reg;
                PPM_ADDR_DIR: bus_rdata <= pin_direction_reg;
                PPM_ADDR_LATCH: bus_rdata <= pin_output_latch_reg;
                PPM_ADDR_MCU_CONTROL: bus_rdata <= mcu_control_reg;
                default: bus_rdata <= 8'h00;
            endcase
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    // -----------------------------------------------------------------
    // alternate function overrides of port b
    // -----------------------------------------------------------------
    logic spi_master_on;
    logic oc_en;
    assign spi_master_on = alt_in.spi_enable && alt_in.spi_master;
    assign oc_en = alt_in.timer8_compare_en || alt_in.timer16_compare_en;

    always_comb begin
        ovr = ovr_in;
        // pin 7 compare outputs only reach the pad when its direction bit or a direction override enables the driver
        if (oc_en) begin
            ovr.pin_value_override_en[PPM_OC_PIN] = 1'b1; // RULE15
            ovr.pin_value_override_val[PPM_OC_PIN] = alt_in.timer8_compare_en
                ? alt_in.timer8_compare_out_a : alt_in.timer16_compare_out_c; // RULE15
        end
        if (spi_master_on) begin
            ovr.direction_override_en[PPM_MISO_PIN] = 1'b1; // RULE17
            ovr.direction_override_val[PPM_MISO_PIN] = 1'b0; // RULE17
            ovr.pullup_override_en[PPM_MISO_PIN] = 1'b1; // RULE18
            ovr.pullup_override_val[PPM_MISO_PIN] = pin_output_latch_reg[PPM_MISO_PIN]
                && !mcu_control_reg[PPM_PUD_BIT]; // RULE18
        end else if (alt_in.spi_enable) begin
            ovr.pin_value_override_en[PPM_MISO_PIN] = 1'b1; // RULE17
            ovr.pin_value_override_val[PPM_MISO_PIN] = alt_in.spi_slave_out;
        end
        if (alt_in.prog_mode) begin
            ovr.direction_override_en[PPM_MISO_PIN] = 1'b1; // RULE19
            ovr.direction_override_val[PPM_MISO_PIN] = 1'b1; // RULE19
            ovr.pin_value_override_en[PPM_MISO_PIN] = 1'b1; // RULE19
            ovr.pin_value_override_val[PPM_MISO_PIN] = alt_in.prog_serial_data_out; // RULE19
        end
    end

    // -----------------------------------------------------------------
    // per-pin mux
    // -----------------------------------------------------------------
    ppm_pad_t pad_next;
    logic [7:0] drive_on;
    always_comb begin
        pad_next = '0;
        drive_on = 8'h00;
        in_en = 8'h00;
        clamp_in = 8'h00;
        for (int i = 0; i < 8; i++) begin
            drive_on[i] = ovr.direction_override_en[i] ? ovr.direction_override_val[i]
                : pin_direction_reg[i]; // RULE6 RULE7 RULE21
            pad_next.drive_en_n[i] = !drive_on[i];
            pad_next.drive_level[i] = ovr.pin_value_override_en[i]
                ? ovr.pin_value_override_val[i] : pin_output_latch_reg[i]; // RULE8 RULE21
            pad_next.pullup_en[i] = ovr.pullup_override_en[i] ? ovr.pullup_override_val[i]
                : ({pin_direction_reg[i], pin_output_latch_reg[i],
                    mcu_control_reg[PPM_PUD_BIT]} == PPM_PULLUP_ON_CODE); // RULE4 RULE5 RULE13
            // an enabled external interrupt keeps its input alive through sleep
            in_en[i] = ovr.input_enable_override_en[i] ? ovr.input_enable_override_val[i]
                : (!sleep_clamp_mode || ext_irq_enable[i]); // RULE1 RULE2 RULE10 RULE11
            // a clamped high pin reads low; the wake step then flags an edge
            clamp_in[i] = schmitt_in[i] && in_en[i]; // RULE1 RULE3
        end
    end

    // outputs registered; reset forces tri-state and pull-ups off
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pad_out.drive_level <= 8'h00;
            pad_out.drive_en_n <= 8'hff;
            pad_out.pullup_en <= 8'h00; // RULE14
            global_pullup_disable <= 1'b0;
        end else begin
            pad_out <= pad_next;
            global_pullup_disable <= mcu_control_reg[PPM_PUD_BIT]; // RULE13
        end
    end

    // -----------------------------------------------------------------
    // input paths
    // -----------------------------------------------------------------
    // raw path carries one flop so the top output stays registered; consumers still sync
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            raw_pad_input <= 8'h00;
            timer16_ext_clock_in <= 1'b0;
            pin_change_src <= 5'h00;
        end else begin
            raw_pad_input <= clamp_in; // RULE12
            timer16_ext_clock_in <= clamp_in[PPM_T1_PIN]; // RULE16
            pin_change_src <= clamp_in[7:PPM_PCINT_LO]; // RULE20
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end else begin
            sync1_reg <= clamp_in;
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_input_sample <= 8'h00;
        end else begin
            pin_input_sample <= sync2_reg;
        end
    end
endmodule : ppm_port_mux

//--- rtl/ppm_pkg.sv
// package for the port pin override multiplexer of port b
//
// Contract
// RULE1: sleep clamp in power-down, power-save, standby
// RULE2: enabled external interrupt pins escape sleep clamp
// RULE3: clamped high interrupt pin flags on wake
// RULE4: pull-up follows override, else ddr,latch,pud = 010
// RULE5: pull-up override value wins over register bits
// RULE6: direction override selects driver enable source
// RULE7: direction override value ignores direction bit
// RULE8: driven level from value override or latch
// RULE9: toggle override inverts output latch bit
// RULE10: input enable follows override or sleep state
// RULE11: input enable override wins in any state
// RULE12: alternate functions get unsynchronised schmitt output
// RULE13: global pull-up disable at control bit 4
// RULE14: pull-ups inactive while held in reset
// RULE15: pin 7 carries both timer compare outputs
// RULE16: pin 4 feeds 16-bit timer external clock
// RULE17: spi master forces pin 3 input
// RULE18: forced input pin 3 keeps latch pull-up
// RULE19: pin 3 drives serial programming data out
// RULE20: pins 3..7 are pin-change interrupt sources
// RULE21: direction one drives latch level, zero inputs
// RULE22: writing one to input bit toggles latch
// RULE23: override muxes combinational, registers on clock
package ppm_pkg;
    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [3:0] PPM_ADDR_INPUT = 4'h0;
    localparam logic [3:0] PPM_ADDR_DIR = 4'h1;
    localparam logic [3:0] PPM_ADDR_LATCH = 4'h2;
    localparam logic [3:0] PPM_ADDR_MCU_CONTROL = 4'h3;
    localparam logic [7:0] PPM_MCU_CONTROL_RESET = 8'h00;
    localparam logic [7:0] PPM_MCU_CONTROL_WMASK = 8'h93;
    localparam int PPM_PUD_BIT = 4;
    localparam logic [7:0] PPM_PORT_RESET = 8'h00;
    localparam logic [2:0] PPM_PULLUP_ON_CODE = 3'b010;
    localparam int PPM_MISO_PIN = 3;
    localparam int PPM_T1_PIN = 4;
    localparam int PPM_OC_PIN = 7;
    localparam int PPM_PCINT_LO = 3;

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ppm_bus_req_t;

    typedef struct packed {
        logic [7:0] pullup_override_en;
        logic [7:0] pullup_override_val;
        logic [7:0] direction_override_en;
        logic [7:0] direction_override_val;
        logic [7:0] pin_value_override_en;
        logic [7:0] pin_value_override_val;
        logic [7:0] latch_toggle_override_en;
        logic [7:0] input_enable_override_en;
        logic [7:0] input_enable_override_val;
    } ppm_override_t;

    typedef struct packed {
        logic timer8_compare_out_a;
        logic timer8_compare_en;
        logic timer16_compare_out_c;
        logic timer16_compare_en;
        logic spi_enable;
        logic spi_master;
        logic spi_slave_out;
        logic prog_mode;
        logic prog_serial_data_out;
    } ppm_alt_t;

    typedef struct packed {
        logic [7:0] drive_level;
        logic [7:0] drive_en_n;
        logic [7:0] pullup_en;
    } ppm_pad_t;
endpackage : ppm_pkg

//--- verif/ppm_port_mux_properties.sv
// concurrent checks on the pad side of the port pin override multiplexer
`timescale 1ns/1ns
module ppm_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire ppm_pkg::ppm_override_t ovr_in,
    input wire ppm_pkg::ppm_alt_t alt_in,
    input wire logic sleep_clamp_mode,
    input wire logic [7:0] ext_irq_enable,
    input wire logic [7:0] schmitt_in,
    input wire ppm_pkg::ppm_pad_t pad_out,
    input wire logic [7:0] raw_pad_input,
    input wire logic timer16_ext_clock_in,
    input wire logic [4:0] pin_change_src
);
    import ppm_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // pads lag inputs by one edge, so the edge after reset release is skipped
    a_pullup_ovr_val: assert property ($past(reset_n) && $past(ovr_in.pullup_override_en[5])
        |-> pad_out.pullup_en[5] == $past(ovr_in.pullup_override_val[5])) else $error("pullup");
    a_dir_ovr_val: assert property ($past(reset_n) && $past(ovr_in.direction_override_en[5])
        |-> pad_out.drive_en_n[5] != $past(ovr_in.direction_override_val[5]))
        else $error("dir override");
    a_level_ovr_val: assert property ($past(reset_n) && !pad_out.drive_en_n[5]
        && $past(ovr_in.pin_value_override_en[5])
        |-> pad_out.drive_level[5] == $past(ovr_in.pin_value_override_val[5]))
        else $error("level override");
    a_input_ovr_val: assert property ($past(reset_n) && $past(ovr_in.input_enable_override_en[5])
        |-> raw_pad_input[5] == ($past(schmitt_in[5]) && $past(ovr_in.input_enable_override_val[5])))
        else $error("input override");
    a_sleep_clamp_gate: assert property ($past(reset_n)
        && !$past(ovr_in.input_enable_override_en[6]) |-> raw_pad_input[6] == ($past(schmitt_in[6])
        && (!$past(sleep_clamp_mode) || $past(ext_irq_enable[6])))) else $error("clamp");
    a_spi_master_input: assert property ($past(reset_n) && $past(alt_in.spi_enable)
        && $past(alt_in.spi_master) && !$past(alt_in.prog_mode)
        && !$past(ovr_in.direction_override_en[3]) |-> pad_out.drive_en_n[3]) else $error("miso");
    a_reset_pads_off: assert property ($rose(reset_n)
        |-> pad_out.drive_en_n == 8'hff && pad_out.pullup_en == 8'h00) else $error("reset pads");
    // awake and without an enable override the clamp is transparent, so judge against the pad
    a_pin_change_src: assert property ($past(reset_n) && !$past(sleep_clamp_mode)
        && $past(ovr_in.input_enable_override_en[7:3]) == 5'h00
        |-> pin_change_src == $past(schmitt_in[7:3])) else $error("pin change");
    a_timer_clock_in: assert property ($past(reset_n) && !$past(sleep_clamp_mode)
        && !$past(ovr_in.input_enable_override_en[4])
        |-> timer16_ext_clock_in == $past(schmitt_in[4])) else $error("timer clock");
    c_sleep_escape: cover property (sleep_clamp_mode && ext_irq_enable[6]);
    c_spi_master: cover property (alt_in.spi_enable && alt_in.spi_master);
    c_prog_mode: cover property (alt_in.prog_mode && !pad_out.drive_en_n[3]);
endmodule : ppm_props
bind ppm_port_mux ppm_props ppm_props_i (.clk(clk), .reset_n(reset_n), .ovr_in(ovr_in),
    .alt_in(alt_in), .sleep_clamp_mode(sleep_clamp_mode), .ext_irq_enable(ext_irq_enable),
    .schmitt_in(schmitt_in), .pad_out(pad_out), .raw_pad_input(raw_pad_input),
    .timer16_ext_clock_in(timer16_ext_clock_in), .pin_change_src(pin_change_src));

//--- verif/ppm_pad_model.sv
// pad wires of port b: resolve design drive, outside drivers and pull-ups
`timescale 1ns/1ns
module ppm_pad_model (
    input wire logic clk,
    input wire ppm_pkg::ppm_pad_t pad_out,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_level,
    output logic [7:0] schmitt_in
);
    import ppm_pkg::*;
    // a floating pad wanders so a stale value never passes for a real one
    logic [7:0] float_reg = 8'h55;
    always_ff @(posedge clk) begin
        float_reg <= ~float_reg;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad_out.drive_en_n[i]) schmitt_in[i] = pad_out.drive_level[i];
            else if (ext_en[i]) schmitt_in[i] = ext_level[i];
            else if (pad_out.pullup_en[i]) schmitt_in[i] = 1'b1;
            else schmitt_in[i] = float_reg[i];
        end
    end
endmodule : ppm_pad_model

//--- verif/tb.sv
// self-checking bench for the port pin override multiplexer
`timescale 1ns/1ns
module tb;
    import ppm_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, sleep_clamp_mode = 1'b0;
    ppm_bus_req_t bus_req = '0;
    ppm_override_t ovr_in = '0;
    ppm_alt_t alt_in = '0;
    ppm_pad_t pad_out;
    logic [7:0] bus_rdata, ext_irq_enable = '0, schmitt_in, raw_pad_input, pin_input_sample;
    logic [7:0] ext_en = '0, ext_level = '0, d;
    logic [4:0] pin_change_src;
    logic timer16_ext_clock_in, global_pullup_disable;
    int fail_count = 0, n_tests = 0;
    ppm_port_mux ppm_port_mux_i (.clk(clk), .reset_n(reset_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .ovr_in(ovr_in), .alt_in(alt_in),
        .sleep_clamp_mode(sleep_clamp_mode), .ext_irq_enable(ext_irq_enable),
        .schmitt_in(schmitt_in), .pad_out(pad_out), .raw_pad_input(raw_pad_input),
        .pin_input_sample(pin_input_sample), .timer16_ext_clock_in(timer16_ext_clock_in),
        .pin_change_src(pin_change_src), .global_pullup_disable(global_pullup_disable));
    ppm_pad_model ppm_pad_model_i (.clk(clk), .pad_out(pad_out), .ext_en(ext_en),
        .ext_level(ext_level), .schmitt_in(schmitt_in));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk) bus_req <= '{a, v, 1'b1, 1'b0};
        @(posedge clk) bus_req <= '0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) bus_req <= '0;
        #1 d = bus_rdata;
    endtask : rd
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask : settle
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    task automatic t_regs();
        rd(PPM_ADDR_MCU_CONTROL);
        chk("ctl reset", d, 8'h00);
        wr(PPM_ADDR_MCU_CONTROL, 8'hff);
        rd(PPM_ADDR_MCU_CONTROL);
        chk("ctl mask", d, 8'h93);
        rd(4'hf);
        chk("unmapped", d, 8'h00);
        wr(PPM_ADDR_MCU_CONTROL, 8'h00);
    endtask : t_regs
    task automatic t_pullup();
        wr(PPM_ADDR_DIR, 8'h00);
        wr(PPM_ADDR_LATCH, 8'h28);
        settle();
        chk("pullup", pad_out.pullup_en, 8'h28);
        wr(PPM_ADDR_MCU_CONTROL, 8'h10);
        settle();
        chk("pud pullup", pad_out.pullup_en, 8'h00);
        chk("pud out", 8'(global_pullup_disable), 8'h01);
        wr(PPM_ADDR_MCU_CONTROL, 8'h00);
    endtask : t_pullup
    task automatic t_drive();
        wr(PPM_ADDR_LATCH, 8'ha5);
        wr(PPM_ADDR_DIR, 8'hff);
        settle();
        chk("drive en", pad_out.drive_en_n, 8'h00);
        chk("level", pad_out.drive_level, 8'ha5);
        wr(PPM_ADDR_INPUT, 8'h0f);
        rd(PPM_ADDR_LATCH);
        chk("toggle", d, 8'haa);
        settle();
        chk("sample", pin_input_sample, 8'haa);
        rd(PPM_ADDR_INPUT);
        chk("input reg", d, 8'haa);
    endtask : t_drive
    task automatic t_ovr();
        for (int k = 0; k < 4; k++) begin
            d = 8'({8'h0f, 8'hf0, 8'h55, 8'h33} >> (8 * k));
            @(posedge clk);
            ovr_in <= '{8'hff, d, 8'hff, d, 8'hff, d, 8'h00, 8'hff, d};
            settle();
            chk("ovr pullup", pad_out.pullup_en, d);
            chk("ovr dir", pad_out.drive_en_n, ~d);
            chk("ovr level", pad_out.drive_level, d);
            chk("ovr input", raw_pad_input, d);
        end
        @(posedge clk);
        ovr_in <= '0;
        @(posedge clk);
        ovr_in.latch_toggle_override_en <= 8'h01;
        @(posedge clk);
        ovr_in <= '0;
        rd(PPM_ADDR_LATCH);
        chk("ovr toggle", d, 8'hab);
    endtask : t_ovr
    task automatic t_sleep();
        wr(PPM_ADDR_DIR, 8'h00);
        @(posedge clk);
        ext_en <= 8'hff;
        ext_level <= 8'hff;
        ext_irq_enable <= 8'h40;
        sleep_clamp_mode <= 1'b1;
        settle();
        chk("clamp", raw_pad_input, 8'h40);
        chk("pcint", 8'(pin_change_src), 8'h08);
        @(posedge clk);
        sleep_clamp_mode <= 1'b0;
        settle();
        chk("awake", raw_pad_input, 8'hff);
        chk("t1", 8'(timer16_ext_clock_in), 8'h01);
        @(posedge clk);
        ext_en <= 8'h00;
    endtask : t_sleep
    task automatic t_alt();
        wr(PPM_ADDR_LATCH, 8'h08);
        wr(PPM_ADDR_DIR, 8'h88);
        @(posedge clk);
        alt_in <= 9'h018;
        settle();
        chk("miso in", 8'(pad_out.drive_en_n[3]), 8'h01);
        chk("miso pull", 8'(pad_out.pullup_en[3]), 8'h01);
        @(posedge clk);
        alt_in <= 9'h014;
        settle();
        chk("slave", 8'({pad_out.drive_en_n[3], pad_out.drive_level[3]}), 8'h01);
        @(posedge clk);
        alt_in <= 9'h002;
        settle();
        chk("prog", 8'({pad_out.drive_en_n[3], pad_out.drive_level[3]}), 8'h00);
        @(posedge clk);
        alt_in <= 9'h0e0;
        settle();
        chk("oc both", 8'(pad_out.drive_level[7]), 8'h00);
        chk("oc drive", 8'(pad_out.drive_en_n[7]), 8'h00);
        @(posedge clk);
        alt_in <= 9'h060;
        settle();
        chk("oc c", 8'(pad_out.drive_level[7]), 8'h01);
        @(posedge clk);
        alt_in <= '0;
    endtask : t_alt
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_pullup();
        t_drive();
        t_ovr();
        t_sleep();
        t_alt();
        final_report();
    end
    initial begin
        #20000;
        fail_count++;
        final_report();
    end
endmodule : tb
